// [shared/edr_dma_regs.svh]
// Purpose: Register offsets, field positions and reset values of the DMA block
// Assumes: Offsets are low byte-address bits below the block's APB base
// Notes:   Definitions only
`ifndef EDR_DMA_REGS_SVH
`define EDR_DMA_REGS_SVH

`define EDR_FLAG_STATUS_OFF 8'h00
`define EDR_FLAG_CLEAR_OFF  8'h04
`define EDR_CH0_OFF         8'h08
`define EDR_CH_STRIDE       8'h14
`define EDR_CH_SPAN         8'h10

`define EDR_CONFIG_OFF      2'h0
`define EDR_COUNT_OFF       2'h1
`define EDR_PERIPH_OFF      2'h2
`define EDR_MEMORY_OFF      2'h3

`define EDR_CFG_EN          0
`define EDR_CFG_COMPLETE_IE 1
`define EDR_CFG_HALF_IE     2
`define EDR_CFG_ERROR_IE    3
`define EDR_CFG_DIR         4
`define EDR_CFG_WRAP        5
`define EDR_CFG_PSTEP       6
`define EDR_CFG_MSTEP       7
`define EDR_CFG_PWIDTH      8
`define EDR_CFG_MWIDTH      10
`define EDR_CFG_PRIO        12
`define EDR_CFG_COPY        14
`define EDR_CFG_BITS        15

`define EDR_FLAG_GLOBAL     0
`define EDR_FLAG_COMPLETE   1
`define EDR_FLAG_HALF       2
`define EDR_FLAG_ERROR      3
`define EDR_FLAG_BITS       4

`define EDR_WIDTH_BYTE      2'b00
`define EDR_WIDTH_HALF      2'b01

`define EDR_REG_RESET       32'h0000_0000

`endif

// [shared/edr_pkg.sv]
// Purpose: Types shared by the DMA block
// Assumes: Nothing
// Notes:   Bus request and answer carriers for the data mover
package edr_pkg;

  typedef enum logic [2:0] {
    EDR_IDLE  = 3'b001,
    EDR_READ  = 3'b010,
    EDR_WRITE = 3'b100
  } edr_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } edr_bus_req_t;

  typedef struct packed {
    logic        ready;
    logic        err;
    logic [31:0] rdata;
  } edr_bus_rsp_t;

endpackage : edr_pkg

// [design/edr_dma.sv]
// Purpose: Eight-channel DMA register set, arbiter and data mover
// Assumes: APB slave with no wait states; one data bus master port
// Notes:   A transfer is one read of the source then one write of the target
`timescale 1ns/1ps
`include "edr_dma_regs.svh"

module edr_dma
  import edr_pkg::*;
#(
  parameter int NCH = 8
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NCH-1:0]     periph_req,
  output logic      [NCH-1:0]     periph_ack,
  output edr_bus_req_t            bus_req,
  input  wire edr_bus_rsp_t       bus_rsp,
  output logic      [NCH-1:0]     chan_irq
);

  logic [`EDR_CFG_BITS-1:0]  cfg_reg   [NCH];
  logic [15:0]               cnt_reg   [NCH];
  logic [15:0]               load_reg  [NCH];
  logic [31:0]               pbase_reg [NCH];
  logic [31:0]               mbase_reg [NCH];
  logic [31:0]               pcur_reg  [NCH];
  logic [31:0]               mcur_reg  [NCH];
  logic [`EDR_FLAG_BITS-1:0] flag_reg  [NCH];

  edr_state_t                state_reg;
  logic [2:0]                cur_reg;
  logic [31:0]               prdata_reg;
  logic                      pslverr_reg;

  logic [7:0]                off;
  logic [7:0]                base;
  logic [7:0]                rel;
  logic                      hit_ch;
  logic [2:0]                hit_idx;
  logic [1:0]                hit_sel;
  logic                      hit_status;
  logic                      hit_clear;
  logic [31:0]               rd_mux;
  logic                      wr_cycle;
  logic                      setup_cycle;

  logic [NCH-1:0]            pend;
  logic                      any_pend;
  logic [2:0]                grant;
  logic [1:0]                best_prio;
  logic                      done_ev;
  logic                      err_ev;

  function automatic logic [31:0] edr_align(input logic [31:0] a, input logic [1:0] w);
    if (w == `EDR_WIDTH_BYTE)
      edr_align = a;
    else if (w == `EDR_WIDTH_HALF)
      edr_align = {a[31:1], 1'b0};
    else
      edr_align = {a[31:2], 2'b00};
  endfunction : edr_align

  function automatic logic [31:0] edr_bytes(input logic [1:0] w);
    if (w == `EDR_WIDTH_BYTE)
      edr_bytes = 32'h0000_0001;
    else if (w == `EDR_WIDTH_HALF)
      edr_bytes = 32'h0000_0002;
    else
      edr_bytes = 32'h0000_0004;
  endfunction : edr_bytes

  assign off         = paddr[7:0];
  assign setup_cycle = psel && !penable;
  assign wr_cycle    = psel && penable && pwrite;
  assign pready      = 1'b1;
  assign prdata      = prdata_reg;
  assign pslverr     = pslverr_reg;

  // Address decode of the flag pair and the eight channel groups
  always_comb
  begin
    hit_ch     = 1'b0;
    hit_idx    = 3'h0;
    hit_sel    = 2'h0;
    base       = 8'h00;
    rel        = 8'h00;
    hit_status = (off == `EDR_FLAG_STATUS_OFF);
    hit_clear  = (off == `EDR_FLAG_CLEAR_OFF);
    for (int i = 0; i < NCH; i++)
    begin
      base = 8'(`EDR_CH0_OFF + i * `EDR_CH_STRIDE);
      rel  = off - base;
      if (off >= base && rel < `EDR_CH_SPAN && rel[1:0] == 2'b00)
      begin
        hit_ch  = 1'b1;
        hit_idx = 3'(i);
        hit_sel = rel[3:2];
      end
    end
  end

  always_comb
  begin
    rd_mux = `EDR_REG_RESET;
    if (hit_status)
    begin
      for (int i = 0; i < NCH; i++)
        rd_mux[i*`EDR_FLAG_BITS +: `EDR_FLAG_BITS] = flag_reg[i];
    end
    else if (hit_ch)
    begin
      case (hit_sel)
        `EDR_CONFIG_OFF: rd_mux = {17'h0, cfg_reg[hit_idx]};
        `EDR_COUNT_OFF:  rd_mux = {16'h0, cnt_reg[hit_idx]};
        `EDR_PERIPH_OFF: rd_mux = pbase_reg[hit_idx];
        `EDR_MEMORY_OFF: rd_mux = mbase_reg[hit_idx];
        default:         rd_mux = `EDR_REG_RESET;
      endcase
    end
  end

  // Read data and error answer are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= `EDR_REG_RESET;
      pslverr_reg <= 1'b0;
    end
    else if (setup_cycle)
    begin
      prdata_reg  <= pwrite ? `EDR_REG_RESET : rd_mux;
      pslverr_reg <= !(hit_ch || hit_status || hit_clear);
    end
  end

  // Arbiter: highest level wins, ties to the lowest channel
  always_comb
  begin
    any_pend  = 1'b0;
    grant     = 3'h0;
    best_prio = 2'b00;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      pend[i] = cfg_reg[i][`EDR_CFG_EN] && (cnt_reg[i] != 16'h0000) &&
                (cfg_reg[i][`EDR_CFG_COPY] || periph_req[i]);
      if (pend[i] && (!any_pend || cfg_reg[i][`EDR_CFG_PRIO +: 2] >= best_prio))
      begin
        any_pend  = 1'b1;
        grant     = 3'(i);
        best_prio = cfg_reg[i][`EDR_CFG_PRIO +: 2];
      end
    end
  end

  assign done_ev = (state_reg == EDR_WRITE) && bus_rsp.ready && !bus_rsp.err;
  assign err_ev  = (state_reg != EDR_IDLE) && bus_rsp.ready && bus_rsp.err;

  // Data mover: read the source, then write the target
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= EDR_IDLE;
      cur_reg   <= 3'h0;
      bus_req   <= '0;
    end
    else
    begin
      case (state_reg)
        EDR_IDLE:
        begin
          if (any_pend)
          begin
            cur_reg       <= grant;
            bus_req.valid <= 1'b1;
            bus_req.write <= 1'b0;
            bus_req.wdata <= `EDR_REG_RESET;
            if (cfg_reg[grant][`EDR_CFG_DIR])
            begin
              bus_req.size <= cfg_reg[grant][`EDR_CFG_MWIDTH +: 2];
              bus_req.addr <= edr_align(mcur_reg[grant],
                                        cfg_reg[grant][`EDR_CFG_MWIDTH +: 2]);
            end
            else
            begin
              bus_req.size <= cfg_reg[grant][`EDR_CFG_PWIDTH +: 2];
              bus_req.addr <= edr_align(pcur_reg[grant],
                                        cfg_reg[grant][`EDR_CFG_PWIDTH +: 2]);
            end
            state_reg <= EDR_READ;
          end
        end
        EDR_READ:
        begin
          if (bus_rsp.ready && bus_rsp.err)
          begin
            bus_req.valid <= 1'b0;
            state_reg     <= EDR_IDLE;
          end
          else if (bus_rsp.ready)
          begin
            bus_req.write <= 1'b1;
            bus_req.wdata <= bus_rsp.rdata;
            if (cfg_reg[cur_reg][`EDR_CFG_DIR])
            begin
              bus_req.size <= cfg_reg[cur_reg][`EDR_CFG_PWIDTH +: 2];
              bus_req.addr <= edr_align(pcur_reg[cur_reg],
                                        cfg_reg[cur_reg][`EDR_CFG_PWIDTH +: 2]);
            end
            else
            begin
              bus_req.size <= cfg_reg[cur_reg][`EDR_CFG_MWIDTH +: 2];
              bus_req.addr <= edr_align(mcur_reg[cur_reg],
                                        cfg_reg[cur_reg][`EDR_CFG_MWIDTH +: 2]);
            end
            state_reg <= EDR_WRITE;
          end
        end
        EDR_WRITE:
        begin
          if (bus_rsp.ready)
          begin
            bus_req.valid <= 1'b0;
            bus_req.write <= 1'b0;
            state_reg     <= EDR_IDLE;
          end
        end
        default:
        begin
          bus_req   <= '0;
          state_reg <= EDR_IDLE;
        end
      endcase
    end
  end

  // Per-channel registers, address walk, count and flags
  for (genvar g = 0; g < NCH; g++)
  begin : gen_ch
    logic                      mine;
    logic                      cfg_wr;
    logic                      cnt_wr;
    logic                      last;
    logic [15:0]               cnt_dec;
    logic [`EDR_FLAG_BITS-1:0] set_bits;
    logic [`EDR_FLAG_BITS-1:0] clr_bits;
    logic [`EDR_FLAG_BITS-1:0] wr_bits;

    assign mine    = (cur_reg == 3'(g));
    assign cfg_wr  = wr_cycle && hit_ch && hit_idx == 3'(g) && hit_sel == `EDR_CONFIG_OFF;
    assign cnt_wr  = wr_cycle && hit_ch && hit_idx == 3'(g) && hit_sel == `EDR_COUNT_OFF;
    assign cnt_dec = cnt_reg[g] - 16'h0001;
    assign last    = (cnt_reg[g] == 16'h0001);
    assign periph_ack[g] = done_ev && mine;
    assign wr_bits = pwdata[g*`EDR_FLAG_BITS +: `EDR_FLAG_BITS];

    always_comb
    begin
      set_bits = '0;
      set_bits[`EDR_FLAG_COMPLETE] = done_ev && mine && last;
      set_bits[`EDR_FLAG_HALF]     = done_ev && mine && cnt_dec == (load_reg[g] >> 1);
      set_bits[`EDR_FLAG_ERROR]    = err_ev && mine;
      set_bits[`EDR_FLAG_GLOBAL]   = |set_bits[`EDR_FLAG_BITS-1:1];
      clr_bits = '0;
      if (wr_cycle && hit_clear)
        clr_bits = wr_bits[`EDR_FLAG_GLOBAL] ? '1 : wr_bits;
    end

    // A flag set in the same cycle as its clear survives
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        flag_reg[g] <= '0;
      else
        flag_reg[g] <= (flag_reg[g] & ~clr_bits) | set_bits;
    end

    assign chan_irq[g] =
      (flag_reg[g][`EDR_FLAG_COMPLETE] && cfg_reg[g][`EDR_CFG_COMPLETE_IE]) ||
      (flag_reg[g][`EDR_FLAG_HALF]     && cfg_reg[g][`EDR_CFG_HALF_IE]) ||
      (flag_reg[g][`EDR_FLAG_ERROR]    && cfg_reg[g][`EDR_CFG_ERROR_IE]);

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cfg_reg[g] <= '0;
      else if (err_ev && mine)
        cfg_reg[g][`EDR_CFG_EN] <= 1'b0;
      else if (cfg_wr)
        cfg_reg[g] <= pwdata[`EDR_CFG_BITS-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        pbase_reg[g] <= `EDR_REG_RESET;
        mbase_reg[g] <= `EDR_REG_RESET;
      end
      else if (wr_cycle && hit_ch && hit_idx == 3'(g))
      begin
        if (hit_sel == `EDR_PERIPH_OFF)
          pbase_reg[g] <= pwdata;
        if (hit_sel == `EDR_MEMORY_OFF)
          mbase_reg[g] <= pwdata;
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        cnt_reg[g]  <= 16'h0000;
        load_reg[g] <= 16'h0000;
      end
      else if (cnt_wr && !cfg_reg[g][`EDR_CFG_EN])
      begin
        cnt_reg[g]  <= pwdata[15:0];
        load_reg[g] <= pwdata[15:0];
      end
      else if (done_ev && mine)
      begin
        if (last && cfg_reg[g][`EDR_CFG_WRAP])
          cnt_reg[g] <= load_reg[g];
        else
          cnt_reg[g] <= cnt_dec;
      end
    end

    // Working addresses start from the bases when the channel is enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        pcur_reg[g] <= `EDR_REG_RESET;
        mcur_reg[g] <= `EDR_REG_RESET;
      end
      else if (cfg_wr && pwdata[`EDR_CFG_EN] && !cfg_reg[g][`EDR_CFG_EN])
      begin
        pcur_reg[g] <= pbase_reg[g];
        mcur_reg[g] <= mbase_reg[g];
      end
      else if (done_ev && mine)
      begin
        if (last && cfg_reg[g][`EDR_CFG_WRAP])
        begin
          pcur_reg[g] <= pbase_reg[g];
          mcur_reg[g] <= mbase_reg[g];
        end
        else
        begin
          if (cfg_reg[g][`EDR_CFG_PSTEP])
            pcur_reg[g] <= pcur_reg[g] + edr_bytes(cfg_reg[g][`EDR_CFG_PWIDTH +: 2]);
          if (cfg_reg[g][`EDR_CFG_MSTEP])
            mcur_reg[g] <= mcur_reg[g] + edr_bytes(cfg_reg[g][`EDR_CFG_MWIDTH +: 2]);
        end
      end
    end
  end

endmodule : edr_dma

// [dv/edr_dma_chk.sv]
// Purpose: Port checks on the DMA block
// Assumes: One clock, presetn low clears all
// Notes:   Attached by bind at the foot
`timescale 1ns/1ps
module edr_dma_chk
  import edr_pkg::*;
#(
  parameter int NCH = 8
)(
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [31:0]    paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire logic [NCH-1:0] periph_req,
  input wire logic [NCH-1:0] periph_ack,
  input wire edr_bus_req_t   bus_req,
  input wire edr_bus_rsp_t   bus_rsp,
  input wire logic [NCH-1:0] chan_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_read_done;
    bus_req.valid && !bus_req.write && bus_rsp.ready && !bus_rsp.err;
  endsequence
  sequence s_write_done;
    bus_req.valid && bus_req.write && bus_rsp.ready && !bus_rsp.err;
  endsequence
  a_hold_request: assert property (
    bus_req.valid && !bus_rsp.ready |=> $stable(bus_req)) else $error("request moved");
  a_read_first: assert property (
    $rose(bus_req.valid) |-> !bus_req.write) else $error("beat not a read");
  a_pass_data: assert property (
    s_read_done |=> bus_req.write && bus_req.wdata == $past(bus_rsp.rdata))
    else $error("data not passed");
  a_write_gap: assert property (
    s_write_done |=> !bus_req.valid) else $error("no idle after write");
  a_error_stop: assert property (
    bus_req.valid && bus_rsp.ready && bus_rsp.err |=> !bus_req.valid)
    else $error("error did not stop");
  a_half_align: assert property (
    bus_req.valid && bus_req.size == 2'b01 |-> !bus_req.addr[0]) else $error("half unaligned");
  a_word_align: assert property (
    bus_req.valid && bus_req.size[1] |-> bus_req.addr[1:0] == 2'b00)
    else $error("word unaligned");
  a_unmapped_err: assert property (
    psel && !penable && paddr[7:0] >= 8'ha4 |=> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
endmodule : edr_dma_chk

bind edr_dma edr_dma_chk #(.NCH(NCH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
  .periph_ack(periph_ack), .bus_req(bus_req), .bus_rsp(bus_rsp), .chan_irq(chan_irq)
);

// [dv/edr_bus_model.sv]
// Purpose: Memory and peripheral side of the data master
// Assumes: One answer per beat, then one quiet cycle, or at least three when slow
// Notes:   Read data is the address mixed with a key
`timescale 1ns/1ps
module edr_bus_model
  import edr_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         slow,
  input  wire logic         fail,
  input  wire edr_bus_req_t bus_req,
  output edr_bus_rsp_t      bus_rsp
);
  int wait_cnt;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_rsp <= '0;
      wait_cnt <= 0;
    end
    else if (bus_req.valid && !bus_rsp.ready && wait_cnt == 0)
    begin
      bus_rsp <= '{1'b1, fail, bus_req.addr ^ 32'h3c3c_0f0f};
      wait_cnt <= slow ? 3 : 0;
    end
    else
    begin
      // Outside an answer the data shows the inverse of its last value
      bus_rsp <= '{1'b0, 1'b0, ~bus_rsp.rdata};
      wait_cnt <= (wait_cnt > 0 && bus_req.valid) ? wait_cnt - 1 : wait_cnt;
    end
  end
endmodule : edr_bus_model

// [dv/edr_dma_tb_top.sv]
// Purpose: Self-checking bench for the DMA block
// Assumes: APB master here, bus model on the data port
// Notes:   Expected beats kept in queues
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module edr_dma_tb_top
  import edr_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, fail = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rdv, ex_s, ex_d, pb, mb, v;
  logic pready, pslverr, perr;
  logic [7:0] periph_req = '0, periph_ack, chan_irq;
  edr_bus_req_t bus_req;
  edr_bus_rsp_t bus_rsp;
  logic [31:0] src_q[$], dst_q[$];
  int failures = 0, samples_checked = 0, cyc = 0, seed = 32'h8a4d3fef;
  always #4 pclk = ~pclk;
  edr_dma u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_req(periph_req), .periph_ack(periph_ack),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .chan_irq(chan_irq));
  edr_bus_model u_mem (.pclk(pclk), .presetn(presetn), .slow(slow), .fail(fail),
    .bus_req(bus_req), .bus_rsp(bus_rsp));
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  function automatic logic [31:0] ra(int k, int r);
    return 32'(8 + 20 * k + 4 * r);
  endfunction : ra
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    `CHK(rdv, e)
  endtask : rd
  task automatic wait_clr(input logic [31:0] a, m);
    int n = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rdv & m) !== 32'h0 && n < 60);
  endtask : wait_clr
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      failures++;
      tally_and_finish();
    end
    if (|periph_ack) periph_req <= periph_req & ~periph_ack;
    if (presetn && bus_req.valid && bus_req.write && bus_rsp.ready && !bus_rsp.err)
    begin
      ex_d = dst_q.pop_front();
      ex_s = src_q.pop_front();
      `CHK(bus_req.addr, ex_d)
      `CHK(bus_req.wdata, ex_s ^ 32'h3c3c_0f0f)
    end
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 8; k++)
    begin
      for (int r = 0; r < 4; r++) rd(ra(k, r), 32'h0);
      pb = $random(seed);
      mb = $random(seed);
      v = $random(seed);
      apb(1'b1, ra(k, 1), v & 32'hffff);
      apb(1'b1, ra(k, 2), pb);
      apb(1'b1, ra(k, 3), mb);
      apb(1'b1, ra(k, 0), v & 32'h7ffe);
      rd(ra(k, 0), v & 32'h7ffe);
      rd(ra(k, 1), v & 32'hffff);
      rd(ra(k, 2), pb);
      rd(ra(k, 3), mb);
    end
    rd(32'ha4, 32'h0);
    `CHK(perr, 1'b1)
    $display("test registers done");
    pb = $random(seed);
    mb = $random(seed) & 32'hffff_fffc;
    for (int i = 0; i < 4; i++)
    begin
      src_q.push_back(pb & 32'hffff_fffc);
      dst_q.push_back(mb + 4 * i);
    end
    slow <= 1'b1;
    apb(1'b1, ra(2, 1), 32'h4);
    apb(1'b1, ra(2, 2), pb);
    apb(1'b1, ra(2, 3), mb);
    apb(1'b1, ra(2, 0), 32'h4a83);
    wait_clr(ra(2, 1), 32'hffff);
    `CHK(dst_q.size(), 0)
    rd(32'h0, 32'h700);
    `CHK(chan_irq[2], 1'b1)
    apb(1'b1, 32'h4, 32'h200);
    rd(32'h0, 32'h500);
    `CHK(chan_irq[2], 1'b0)
    apb(1'b1, 32'h4, 32'h0);
    rd(32'h0, 32'h500);
    apb(1'b1, 32'h4, 32'h100);
    rd(32'h0, 32'h0);
    apb(1'b1, ra(2, 1), 32'h9);
    rd(ra(2, 1), 32'h0);
    $display("test transfer done");
    fail <= 1'b1;
    apb(1'b1, ra(7, 1), 32'h2);
    apb(1'b1, ra(7, 0), 32'h4009);
    wait_clr(ra(7, 0), 32'h1);
    fail <= 1'b0;
    rd(32'h0, 32'h9000_0000);
    `CHK(chan_irq[7], 1'b1)
    apb(1'b1, 32'h4, 32'h8000_0000);
    rd(32'h0, 32'h1000_0000);
    apb(1'b1, 32'h4, 32'h1000_0000);
    rd(32'h0, 32'h0);
    $display("test error done");
    slow <= 1'b0;
    for (int k = 6; k > 4; k--)
    begin
      pb = $random(seed);
      mb = $random(seed);
      src_q.push_back(pb);
      dst_q.push_back(mb);
      apb(1'b1, ra(k, 1), 32'h1);
      apb(1'b1, ra(k, 2), pb);
      apb(1'b1, ra(k, 3), mb);
      apb(1'b1, ra(k, 0), k == 6 ? 32'h2001 : 32'h1);
    end
    periph_req <= 8'h60;
    wait_clr(ra(5, 1), 32'hffff);
    $display("test priority done");
    // Two very high channels asking together: the lower number goes first
    for (int k = 0; k < 2; k++)
    begin
      pb = $random(seed);
      mb = $random(seed);
      src_q.push_back(pb);
      dst_q.push_back(mb);
      apb(1'b1, ra(k, 1), 32'h1);
      apb(1'b1, ra(k, 2), pb);
      apb(1'b1, ra(k, 3), mb);
      apb(1'b1, ra(k, 0), 32'h3001);
    end
    periph_req <= 8'h03;
    wait_clr(ra(1, 1), 32'hffff);
    `CHK(dst_q.size(), 0)
    `CHK(periph_req, 8'h00)
    rd(32'h0, 32'h0770_0077);
    apb(1'b1, 32'h4, 32'h1111_1111);
    rd(32'h0, 32'h0);
    $display("test tie done");
    // Memory to peripheral, halfwords, peripheral step, wrap after two
    pb = $random(seed);
    mb = $random(seed);
    for (int i = 0; i < 3; i++)
    begin
      src_q.push_back(mb & 32'hffff_fffe);
      dst_q.push_back((pb & 32'hffff_fffe) + 32'(2 * (i % 2)));
    end
    apb(1'b1, ra(3, 1), 32'h2);
    apb(1'b1, ra(3, 2), pb);
    apb(1'b1, ra(3, 3), mb);
    apb(1'b1, ra(3, 0), 32'h575);
    for (int i = 0; i < 3; i++)
    begin
      periph_req[3] <= 1'b1;
      @(posedge pclk);
      while (periph_req[3] === 1'b1) @(posedge pclk);
    end
    `CHK(dst_q.size(), 0)
    rd(ra(3, 1), 32'h1);
    rd(32'h0, 32'h7000);
    `CHK(chan_irq, 8'h08)
    apb(1'b1, 32'h4, 32'h4000);
    rd(32'h0, 32'h3000);
    `CHK(chan_irq, 8'h00)
    $display("test wrap done");
    tally_and_finish();
  end
endmodule : edr_dma_tb_top
